// ==== shared/meas_ctl_pkg.sv ====
// package: command codes, reply codes, register map and field layouts for measurement state control
package meas_ctl_pkg;

  // command opcodes
  localparam logic [3:0] CMD_CLEAR_SURGE_PEAKS   = 4'h1;
  localparam logic [3:0] CMD_LOG_RECORDING       = 4'h2;
  localparam logic [3:0] CMD_LOG_RECORDING_QUERY = 4'h3;
  localparam logic [3:0] CMD_HISTORY             = 4'h4;
  localparam logic [3:0] CMD_HISTORY_QUERY       = 4'h5;
  localparam logic [3:0] CMD_HOLD                = 4'h6;
  localparam logic [3:0] CMD_HOLD_QUERY          = 4'h7;
  localparam logic [3:0] CMD_ACCUMULATION_CTRL   = 4'h8;
  localparam logic [3:0] CMD_ACCUMULATION_QUERY  = 4'h9;

  // register offsets
  localparam logic [3:0] REG_COMMAND  = 4'h0;
  localparam logic [3:0] REG_REPLY    = 4'h4;
  localparam logic [3:0] REG_ERROR    = 4'h8;
  localparam logic [3:0] REG_STATUS   = 4'hc;
  localparam logic [3:0] REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_MASK = 4'h1;
  localparam logic [3:0] REG_DELAY    = 4'h2;

  // command word fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_ARG_LSB   = 4;
  localparam int CMD_INST_LSB  = 8;

  // analyzer instances available; arbitrary build value
  localparam logic [1:0] INST_COUNT = 2'h3;

  // logging termination codes
  localparam logic [2:0] LOG_ERR_NONE    = 3'h0;
  localparam logic [2:0] LOG_ERR_SIZE    = 3'h1;
  localparam logic [2:0] LOG_ERR_FULL    = 3'h2;
  localparam logic [2:0] LOG_ERR_WRITE   = 3'h3;
  localparam logic [2:0] LOG_ERR_REMOVED = 3'h4;

  // integration reply values
  localparam logic [1:0] ACC_IDLE    = 2'h0;
  localparam logic [1:0] ACC_WAITING = 2'h1;
  localparam logic [1:0] ACC_HELD    = 2'h2;
  localparam logic [1:0] ACC_RUNNING = 2'h3;

  // error register codes
  localparam logic [1:0] ERR_NONE     = 2'h0;
  localparam logic [1:0] ERR_INSTANCE = 2'h1;
  localparam logic [1:0] ERR_RANGE    = 2'h2;
  localparam logic [1:0] ERR_OPCODE   = 2'h3;

  // reset value of the start delay, in measurement periods
  localparam logic [15:0] DELAY_RESET = 16'h0000;

  // interrupt status bit positions and width
  localparam int IRQ_CMD_ERR  = 0;
  localparam int IRQ_LOG_END  = 1;
  localparam int IRQ_SURGE_OK = 2;
  localparam int IRQ_ACC_GO   = 3;
  localparam int IRQ_W        = 4;

  // accumulation state codes
  typedef enum logic [1:0] {
    ACC_S_IDLE = 2'b00,
    ACC_S_WAIT = 2'b01,
    ACC_S_RUN  = 2'b11,
    ACC_S_HOLD = 2'b10
  } acc_state_t;

  // logging termination report from the recorder
  typedef struct packed {
    logic       ended;
    logic [2:0] cause;
  } log_end_t;

  // decoded command
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] arg;
    logic [1:0] inst;
  } cmd_t;

endpackage

// ==== rtl/sticky_flag.sv ====
// sticky event bit: hardware set wins over read clear
module sticky_flag (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // control
  input  wire logic set,
  input  wire logic clear,
  // state
  output logic      flag
);

  // set takes precedence over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule

// ==== rtl/measurement_state_control.sv ====
// measurement state control: command interpreter for logging, history, hold and integration
// Operation
// RULE_01 - reject unavailable analyzer instance with error
// RULE_02 - clear command clears surge peak results
// RULE_03 - peaks invalid until next period completes
// RULE_04 - logging argument one starts, zero stops
// RULE_05 - logging query field one: zero/one active
// RULE_06 - logging error kept, zeroed at start
// RULE_07 - termination codes: size, full, write, removed
// RULE_08 - history zero stops, one restarts, clears
// RULE_09 - history query returns running state
// RULE_10 - hold one freezes, zero releases
// RULE_11 - hold query returns held state
// RULE_12 - integration one clears, delays, then accumulates
// RULE_13 - integration query: idle, waiting, updating codes
// RULE_14 - hold during integration suspends, reports two
// RULE_15 - out of range argument rejected, state kept
//
// Added by the designer: the plain strobed port and the register offsets.
module measurement_state_control
  import meas_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rdata,
  // measurement engine events
  input  wire logic        period_done,
  input  wire log_end_t    log_end,
  // control outputs to the measurement engine
  output logic             surge_clear,
  output logic             surge_valid,
  output logic             log_active,
  output logic             history_active,
  output logic             history_clear,
  output logic             hold_active,
  output logic             acc_clear,
  output logic             acc_update,
  // interrupt
  output logic             irq
);

  // register file and block state
  logic [2:0]       log_err;
  logic [31:0]      reply;
  logic [1:0]       err_code;
  logic [15:0]      delay_cfg;
  logic [15:0]      delay_cnt;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_stat;
  acc_state_t       acc_state;
  acc_state_t       next_acc_state;
  logic [1:0]       acc_code;

  // decode of the command word
  cmd_t cmd;
  assign cmd.op   = wdata[CMD_OP_LSB +: 4];
  assign cmd.arg  = wdata[CMD_ARG_LSB +: 2];
  assign cmd.inst = wdata[CMD_INST_LSB +: 2];

  wire cmd_wr   = wr_en && (addr == REG_COMMAND);
  wire inst_bad = (cmd.inst >= INST_COUNT); // see RULE_01
  wire arg_bad  = (cmd.arg > 2'h1);         // see RULE_15
  wire op_known = (cmd.op >= CMD_CLEAR_SURGE_PEAKS) && (cmd.op <= CMD_ACCUMULATION_QUERY);
  wire cmd_ok   = cmd_wr && op_known && !inst_bad && !arg_bad;
  wire cmd_err  = cmd_wr && !(op_known && !inst_bad && !arg_bad);

  // one-cycle action strobes, argument bit and delay-expiry level
  wire do_surge   = cmd_ok && (cmd.op == CMD_CLEAR_SURGE_PEAKS);
  wire do_log     = cmd_ok && (cmd.op == CMD_LOG_RECORDING);
  wire do_hist    = cmd_ok && (cmd.op == CMD_HISTORY);
  wire do_hold    = cmd_ok && (cmd.op == CMD_HOLD);
  wire do_acc     = cmd_ok && (cmd.op == CMD_ACCUMULATION_CTRL);
  wire arg_on     = cmd.arg[0];
  wire log_start  = do_log && arg_on;
  wire log_ended  = log_active && log_end.ended;
  wire acc_start  = do_acc && arg_on;
  wire delay_done = (delay_cnt == 16'h0000);

  // mask and start delay register writes
  wire mask_sel  = wr_en && (addr == REG_IRQ_MASK);
  wire delay_sel = wr_en && (addr == REG_DELAY);

  // surge peak clear and validity
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      surge_clear <= 1'b0;
      surge_valid <= 1'b1;
    end else begin
      surge_clear <= do_surge;                   // see RULE_02
      if (do_surge) begin
        surge_valid <= 1'b0;                     // see RULE_03
      end else if (period_done) begin
        surge_valid <= 1'b1;                     // see RULE_03
      end
    end
  end

  // data logging state and termination cause
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      log_active <= 1'b0;
      log_err    <= LOG_ERR_NONE;
    end else if (log_start) begin
      log_active <= 1'b1;                        // see RULE_04
      log_err    <= LOG_ERR_NONE;                // see RULE_06
    end else if (log_ended) begin
      log_active <= 1'b0;
      log_err    <= log_end.cause;               // see RULE_07
    end else if (do_log) begin
      log_active <= 1'b0;                        // see RULE_04
    end
  end

  // history collection
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      history_active <= 1'b0;
      history_clear  <= 1'b0;
    end else begin
      history_clear <= do_hist && arg_on;        // see RULE_08
      if (do_hist) begin
        history_active <= arg_on;                // see RULE_08
      end
    end
  end

  // measurement hold
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_active <= 1'b0;
    end else if (do_hold) begin
      hold_active <= arg_on;                     // see RULE_10
    end
  end

  // accumulation state machine
  always_comb begin
    next_acc_state = acc_state;
    unique case (acc_state)
      ACC_S_IDLE: begin
        if (acc_start) begin
          next_acc_state = ACC_S_WAIT;
        end
      end
      ACC_S_WAIT: begin
        if (do_acc && !arg_on) begin
          next_acc_state = ACC_S_IDLE;
        end else if (delay_done && !acc_start) begin
          next_acc_state = hold_active ? ACC_S_HOLD : ACC_S_RUN;
        end
      end
      ACC_S_RUN: begin
        if (do_acc) begin
          next_acc_state = arg_on ? ACC_S_WAIT : ACC_S_IDLE;
        end else if (hold_active) begin
          next_acc_state = ACC_S_HOLD;           // see RULE_14
        end
      end
      ACC_S_HOLD: begin
        if (do_acc) begin
          next_acc_state = arg_on ? ACC_S_WAIT : ACC_S_IDLE;
        end else if (!hold_active) begin
          next_acc_state = ACC_S_RUN;
        end
      end
    endcase
  end

  // accumulation state and delay count in measurement periods
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc_state <= ACC_S_IDLE;
      delay_cnt <= 16'h0000;
      acc_clear <= 1'b0;
    end else begin
      acc_state <= next_acc_state;
      acc_clear <= acc_start;                    // see RULE_12
      if (acc_start) begin
        delay_cnt <= delay_cfg;                  // see RULE_12
      end else if (acc_state == ACC_S_WAIT && period_done && !delay_done) begin
        delay_cnt <= delay_cnt - 16'h0001;
      end
    end
  end

  assign acc_update = (acc_state == ACC_S_RUN);  // see RULE_14

  // integration reply code
  always_comb begin
    unique case (acc_state)
      ACC_S_IDLE: acc_code = ACC_IDLE;           // see RULE_13
      ACC_S_WAIT: acc_code = ACC_WAITING;        // see RULE_13
      ACC_S_RUN:  acc_code = ACC_RUNNING;        // see RULE_13
      ACC_S_HOLD: acc_code = ACC_HELD;           // see RULE_14
    endcase
  end

  // query replies and error code
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reply    <= 32'h0000_0000;
      err_code <= ERR_NONE;
    end else if (cmd_err) begin
      err_code <= inst_bad ? ERR_INSTANCE :      // see RULE_01
                  arg_bad  ? ERR_RANGE : ERR_OPCODE; // see RULE_15
    end else if (cmd_ok) begin
      err_code <= ERR_NONE;
      unique case (cmd.op)
        CMD_LOG_RECORDING_QUERY: reply <= {13'h0000, log_err, 15'h0000, log_active}; // see RULE_05
        CMD_HISTORY_QUERY:       reply <= {31'h0000_0000, history_active};         // see RULE_09
        CMD_HOLD_QUERY:          reply <= {31'h0000_0000, hold_active};            // see RULE_11
        CMD_ACCUMULATION_QUERY:  reply <= {30'h0000_0000, acc_code};               // see RULE_13
        default:                 reply <= reply;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask  <= '0;
      delay_cfg <= DELAY_RESET;
    end else begin
      if (mask_sel) begin
        irq_mask <= wdata[IRQ_W-1:0];
      end
      if (delay_sel) begin
        delay_cfg <= wdata[15:0];
      end
    end
  end

  // interrupt status, cleared by reading it
  wire stat_rd = rd_en && (addr == REG_IRQ_STAT);
  logic [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_CMD_ERR]  = cmd_err;
  assign irq_ev[IRQ_LOG_END]  = log_ended;
  assign irq_ev[IRQ_SURGE_OK] = period_done && !surge_valid && !do_surge; // a new clear keeps peaks invalid
  assign irq_ev[IRQ_ACC_GO]   = (acc_state == ACC_S_WAIT) && (next_acc_state != ACC_S_WAIT)
                                && (next_acc_state != ACC_S_IDLE);

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_stat
      sticky_flag u_flag (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .set     (irq_ev[gi]),
        .clear   (stat_rd),
        .flag    (irq_stat[gi])
      );
    end
  endgenerate

  assign irq = |(irq_stat & irq_mask);

  // read mux; data stand one cycle after the strobe
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (addr)
        REG_REPLY:  next_rdata = reply;
        REG_ERROR:  next_rdata = {30'h0000_0000, err_code};
        REG_STATUS: next_rdata = {23'h00_0000, surge_valid, acc_code, hold_active,
                                  history_active, log_active, log_err};
        REG_IRQ_MASK: next_rdata = {28'h000_0000, irq_mask};
        REG_DELAY:    next_rdata = {16'h0000, delay_cfg};
        REG_IRQ_STAT: next_rdata = {28'h000_0000, irq_stat};
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

// ==== sim/measurement_state_control_props.sv ====
// checker: port-level assertions for measurement state control
module measurement_state_control_props
  import meas_ctl_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // register port
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  // engine side
  input wire logic        period_done,
  input wire log_end_t    log_end,
  input wire logic        surge_clear,
  input wire logic        surge_valid,
  input wire logic        log_active,
  input wire logic        history_active,
  input wire logic        history_clear,
  input wire logic        hold_active,
  input wire logic        acc_clear,
  input wire logic        acc_update
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // accepted command with a given opcode and argument
  sequence s_set(logic [3:0] op, logic [1:0] arg);
    wr_en && addr == 4'h0 && wdata[3:0] == op && wdata[5:4] == arg && wdata[9:8] != 2'h3;
  endsequence
  // refused command: missing instance, or argument above one on a logging, history, hold or integration command
  sequence s_bad;
    wr_en && addr == 4'h0 && (wdata[9:8] == 2'h3 || (wdata[5:4] > 2'h1 && wdata[3:0] inside {4'h2, 4'h4, 4'h6, 4'h8}));
  endsequence
  AST_LOG_ON: assert property (s_set(4'h2, 2'h1) |=> log_active)
    else $error("logging did not start");
  AST_LOG_OFF: assert property (s_set(4'h2, 2'h0) |=> !log_active)
    else $error("logging did not stop");
  AST_HIST_GO: assert property (s_set(4'h4, 2'h1) |=> history_active && history_clear)
    else $error("history start without clear");
  AST_HOLD_ON: assert property (s_set(4'h6, 2'h1) |=> hold_active)
    else $error("hold not taken");
  AST_SURGE: assert property (s_set(4'h1, 2'h0) ##0 !period_done |=> surge_clear && !surge_valid)
    else $error("surge clear missing");
  AST_SURGE_BACK: assert property ($rose(surge_valid) |-> $past(period_done))
    else $error("surge valid without period");
  AST_BAD_KEEP: assert property (s_bad |=> $stable({history_active, hold_active}) && !acc_clear && (log_active == ($past(log_active) && !$past(log_end.ended))))
    else $error("refused command changed state");
  AST_ACC_GO: assert property (s_set(4'h8, 2'h1) |=> acc_clear)
    else $error("integration start without clear");
  AST_HOLD_STOPS: assert property (hold_active && $past(hold_active) |-> !acc_update)
    else $error("accumulation updates during hold");
  AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule

bind measurement_state_control measurement_state_control_props props (
  .sys_clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata, .period_done, .log_end, .surge_clear,
  .surge_valid, .log_active, .history_active, .history_clear, .hold_active, .acc_clear, .acc_update
);

// ==== sim/meas_engine_model.sv ====
// partner: measurement engine model issuing period and termination events
module meas_engine_model
  import meas_ctl_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // events to the block
  output logic     period_done,
  output log_end_t log_end
);
  // idle at time zero
  initial begin
    period_done = 1'b0;
    log_end     = '0;
  end
  // one-cycle period completion pulse
  task automatic period();
    @(posedge sys_clk);
    period_done <= 1'b1;
    @(posedge sys_clk);
    period_done <= 1'b0;
  endtask
  // one-cycle termination report, cause scrambled once released
  task automatic terminate(input logic [2:0] cause);
    @(posedge sys_clk);
    log_end <= '{ended: 1'b1, cause: cause};
    @(posedge sys_clk);
    log_end <= '{ended: 1'b0, cause: ~cause};
  endtask
endmodule

// ==== sim/measurement_state_control_test.sv ====
// testbench: measurement state control driven through its register port
module measurement_state_control_test
  import meas_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rstn, wr_en, rd_en, period_done, irq;
  logic        surge_clear, surge_valid, log_active, history_active, history_clear, hold_active, acc_clear, acc_update;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, v;
  log_end_t    log_end;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  measurement_state_control dut (.sys_clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata, .period_done,
    .log_end, .surge_clear, .surge_valid, .log_active, .history_active, .history_clear, .hold_active,
    .acc_clear, .acc_update, .irq);
  meas_engine_model eng (.sys_clk, .period_done, .log_end);

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  // compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // bus write and read
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  // command word and query reply
  task automatic cmd(input logic [3:0] op, input logic [1:0] arg, input logic [1:0] inst);
    wr(4'h0, {22'h00_0000, inst, 2'h0, arg, op});
  endtask
  task automatic ask(input logic [3:0] op, input string n, input logic [31:0] exp);
    cmd(op, 2'h0, 2'h0);
    rd(4'h4, v);
    chk(n, exp, v);
  endtask
  // idle state after reset
  task automatic t_reset();
    rd(4'hc, v);
    chk("status", 32'h0000_0100, v);
    rd(4'h5, v);
    chk("unmapped", 32'h0000_0000, v);
  endtask
  // logging with every termination cause
  task automatic t_log();
    wr(4'h1, 32'h0000_000f);
    for (int c = 1; c <= 4; c++) begin
      cmd(CMD_LOG_RECORDING, 2'h1, 2'h0);
      ask(CMD_LOG_RECORDING_QUERY, "log_on", 32'h0000_0001);
      eng.terminate(c[2:0]);
      #1 chk("irq", 32'h0000_0001, 32'(irq));
      ask(CMD_LOG_RECORDING_QUERY, "log_err", {13'h0000, c[2:0], 16'h0000});
      rd(4'h3, v);
      chk("irq_stat", 32'h0000_0002, v);
      chk("irq_clr", 32'h0000_0000, 32'(irq));
    end
    cmd(CMD_LOG_RECORDING, 2'h1, 2'h0);
    ask(CMD_LOG_RECORDING_QUERY, "log_restart", 32'h0000_0001);
    cmd(CMD_LOG_RECORDING, 2'h0, 2'h0);
    ask(CMD_LOG_RECORDING_QUERY, "log_off", 32'h0000_0000);
  endtask
  // history start and stop
  task automatic t_hist();
    cmd(CMD_HISTORY, 2'h1, 2'h0);
    #1 chk("hist_clear", 32'h0000_0001, 32'(history_clear));
    ask(CMD_HISTORY_QUERY, "hist_on", 32'h0000_0001);
    cmd(CMD_HISTORY, 2'h0, 2'h0);
    ask(CMD_HISTORY_QUERY, "hist_off", 32'h0000_0000);
  endtask
  // refused commands leave state alone
  task automatic t_refuse();
    cmd(CMD_HISTORY, 2'h2, 2'h0);
    rd(4'h8, v);
    chk("err_range", 32'h0000_0002, v);
    cmd(CMD_LOG_RECORDING, 2'h1, 2'h3);
    #1 chk("log_kept", 32'h0000_0000, 32'(log_active));
    rd(4'h8, v);
    chk("err_inst", 32'h0000_0001, v);
    cmd(4'hf, 2'h0, 2'h0);
    rd(4'h8, v);
    chk("err_op", 32'h0000_0003, v);
    rd(4'h3, v);
    chk("irq_err", 32'h0000_0001, v);
    ask(CMD_HISTORY_QUERY, "hist_kept", 32'h0000_0000);
  endtask
  // integration with delay and hold
  task automatic t_acc();
    wr(4'h2, 32'h0000_0002);
    cmd(CMD_ACCUMULATION_CTRL, 2'h1, 2'h0);
    #1 chk("acc_clear", 32'h0000_0001, 32'(acc_clear));
    ask(CMD_ACCUMULATION_QUERY, "acc_wait", 32'h0000_0001);
    eng.period();
    ask(CMD_ACCUMULATION_QUERY, "acc_wait1", 32'h0000_0001);
    eng.period();
    ask(CMD_ACCUMULATION_QUERY, "acc_run", 32'h0000_0003);
    chk("acc_run_upd", 32'h0000_0001, 32'(acc_update));
    cmd(CMD_HOLD, 2'h1, 2'h0);
    ask(CMD_HOLD_QUERY, "hold_on", 32'h0000_0001);
    ask(CMD_ACCUMULATION_QUERY, "acc_held", 32'h0000_0002);
    chk("acc_upd", 32'h0000_0000, 32'(acc_update));
    cmd(CMD_HOLD, 2'h0, 2'h0);
    ask(CMD_HOLD_QUERY, "hold_off", 32'h0000_0000);
    ask(CMD_ACCUMULATION_QUERY, "acc_resume", 32'h0000_0003);
    cmd(CMD_ACCUMULATION_CTRL, 2'h0, 2'h0);
    ask(CMD_ACCUMULATION_QUERY, "acc_stop", 32'h0000_0000);
  endtask
  // surge clear, revalidation and masked interrupt
  task automatic t_surge();
    rd(4'h3, v);
    cmd(CMD_CLEAR_SURGE_PEAKS, 2'h0, 2'h0);
    #1 chk("surge_clr", 32'h0000_0001, 32'(surge_clear));
    chk("surge_bad", 32'h0000_0000, 32'(surge_valid));
    wr(4'h1, 32'h0000_0000);
    eng.period();
    #1 chk("surge_ok", 32'h0000_0001, 32'(surge_valid));
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    wr(4'h1, 32'h0000_0004);
    #1 chk("irq_on", 32'h0000_0001, 32'(irq));
    rd(4'h3, v);
    chk("irq_surge", 32'h0000_0004, v);
    chk("irq_off", 32'h0000_0000, 32'(irq));
  endtask
  // counts and verdict
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rstn  = 1'b0;
    addr  = 4'h0;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_log();
    t_hist();
    t_refuse();
    t_acc();
    t_surge();
    print_verdict();
  end
endmodule
